// ### hdl/msb_pkg.sv
package msb_pkg;

	// Number of serial lines and the width of a line number.
	localparam int LINES_DEF = 16;
	localparam int LINE_W    = 4;

	// Silo geometry.
	localparam int SILO_DEPTH = 64;
	localparam int SILO_AW    = 6;
	localparam int CHAR_W     = 8;

	// Register indexes inside the eight-word block (byte address = base + 2 * index).
	localparam logic [2:0] REG_SYS_CTRL    = 3'h0;
	localparam logic [2:0] REG_NEXT_RX     = 3'h1;
	localparam logic [2:0] REG_LINE_PARAM  = 3'h2;
	localparam logic [2:0] REG_CUR_ADDR    = 3'h3;
	localparam logic [2:0] REG_BYTE_COUNT  = 3'h4;
	localparam logic [2:0] REG_BUF_ACTIVE  = 3'h5;
	localparam logic [2:0] REG_BREAK       = 3'h6;
	localparam logic [2:0] REG_SILO_STATUS = 3'h7;

	// The block base must have this many low address bits zero, so it is aligned to 20 octal bytes.
	localparam int BLOCK_ALIGN_BITS = 4;

	// System control word field positions.
	localparam int SC_LINE_LSB  = 0;
	localparam int SC_RX_IE     = 6;
	localparam int SC_RX_INT    = 7;
	localparam int SC_STORE_OVF = 14;

	// Silo status field positions.
	localparam int SS_ALARM_LSB = 0;
	localparam int SS_XADDR_LSB = 6;
	localparam int SS_FILL_LSB  = 8;
	localparam int SS_MAINT     = 15;

	// Fixed maintenance pattern and reset values.
	localparam logic [15:0] MAINT_PATTERN = 16'hAAAA;
	localparam logic [15:0] WORD_RESET    = 16'h0000;

	// Serial frame lengths including start and stop bits.
	localparam logic [3:0] FRAME_BITS     = 4'hA;
	localparam logic [3:0] FRAME_BITS_PAR = 4'hB;
	// Receiver bit position of the stop bit, counted from the first data bit.
	localparam logic [3:0] RX_STOP_POS    = 4'h8;
	localparam logic [3:0] RX_STOP_PAR    = 4'h9;

	// One entry of the silo as it is read back.
	typedef struct packed {
		logic              valid;
		logic              overrun;
		logic              frame_err;
		logic              par_err;
		logic [LINE_W-1:0] line;
		logic [CHAR_W-1:0] data;
	} msb_silo_word_t;

	// One register access from the host bus.
	typedef struct packed {
		logic        sel;
		logic        wr;
		logic        rd;
		logic [1:0]  byte_en;
		logic [17:0] addr;
		logic [15:0] wdata;
	} msb_bus_req_t;

endpackage

// ### hdl/msb_silo_mem.sv
`timescale 1ns/1ps
// Plain storage for the silo; the read word comes out of a register one cycle later.
module msb_silo_mem #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 64,
	parameter int AW    = 6
) (
	input  wire logic             clock_i,
	input  wire logic             wr_en_i,
	input  wire logic [AW-1:0]    wr_addr_i,
	input  wire logic [WIDTH-1:0] wr_data_i,
	input  wire logic             rd_en_i,
	input  wire logic [AW-1:0]    rd_addr_i,
	output logic      [WIDTH-1:0] rd_data_o
);

	// Storage array; no reset, since the pointers define what is valid.
	logic [WIDTH-1:0] mem_q [DEPTH];

	// Write port.
	always_ff @(posedge clock_i) begin
		if (wr_en_i) begin
			mem_q[wr_addr_i] <= wr_data_i;
		end
	end

	// Registered read port.
	always_ff @(posedge clock_i) begin
		if (rd_en_i) begin
			rd_data_o <= mem_q[rd_addr_i];
		end
	end

endmodule

// ### hdl/msb_silo.sv
`timescale 1ns/1ps
module msb_silo
	import msb_pkg::*;
#(
	parameter int          LINES     = 16,
	parameter logic [17:0] BASE_ADDR = 18'h3_E010,
	parameter logic [8:0]  RX_VECTOR = 9'h0C0
) (
	input  wire logic                            clock_i,
	input  wire logic                            rst_n_i,
	input  wire msb_pkg::msb_bus_req_t           bus_req_i,
	output logic      [15:0]                     bus_rdata_o,
	output logic                                 bus_ack_o,
	input  wire logic [LINES-1:0]                rx_serial_i,
	input  wire logic [LINES-1:0]                rx_tick_i,
	input  wire logic [LINES-1:0]                tx_tick_i,
	input  wire logic [LINES-1:0]                parity_en_i,
	input  wire logic [LINES-1:0]                parity_odd_i,
	input  wire logic [LINES-1:0]                tx_load_i,
	input  wire logic [LINES-1:0][7:0]           tx_data_i,
	input  wire logic [LINES-1:0][1:0]           tx_addr_hi_i,
	output logic      [LINES-1:0]                tx_serial_o,
	output logic      [LINES-1:0]                tx_holding_empty_o,
	output logic      [LINES-1:0]                tx_end_of_char_o,
	output logic                                 rx_irq_o,
	output logic      [8:0]                      rx_vector_o,
	output logic      [8:0]                      tx_vector_o
);

	// Elaboration checks: the line field and bitmaps assume sixteen lines.
	if (LINES != LINES_DEF) begin : g_bad_lines
		$error("msb_silo supports exactly sixteen lines");
	end
	if (BASE_ADDR[BLOCK_ALIGN_BITS-1:0] != '0) begin : g_bad_base
		$error("msb_silo base address must be aligned to 20 octal");
	end

	// Control and status state.
	logic [LINE_W-1:0]    line_sel_q;      // Line chosen for per-line reports.
	logic                 rx_ie_q;         // Receiver interrupt enable.
	logic                 ovf_q;           // Storage overflow, sticky.
	logic [SILO_AW-1:0]   alarm_q;         // Silo alarm level.
	logic                 maint_q;         // Silo maintenance bit.
	logic                 maint_prev_q;    // Previous maintenance bit for edge detect.
	logic                 maint_pend_q;    // Pattern load waiting for space.
	logic [LINES-1:0]     line_break_mask_q;
	logic [LINE_W-1:0]    scan_q;          // Receiver scanner position.
	logic                 irq_q;
	logic [15:0]          rdata_q;
	logic                 ack_q;

	// Silo pointers, counters and the output stage.
	logic [SILO_AW-1:0]   wr_ptr_q, rd_ptr_q;
	logic [SILO_AW:0]     mem_cnt_q;       // Words in the memory array.
	logic [SILO_AW:0]     count_q;         // Words in array plus output stage.
	logic                 fetch_q;         // Read from array in flight.
	logic                 head_valid_q;    // A character sits at the output end.
	msb_silo_word_t       head_q;
	msb_silo_word_t       mem_rdata;

	// Per-line receiver holding registers, seen by the scanner.
	logic [LINES-1:0][7:0] rx_hold;
	logic [LINES-1:0]      rx_char_available, rx_ovr, rx_ferr, rx_perr;
	logic [LINES-1:0]      take_vec;

	// Bus decode, combinational.
	logic hit, wr_any, rd_any;
	logic [2:0] reg_idx;
	assign hit     = bus_req_i.sel &&
		(bus_req_i.addr[17:BLOCK_ALIGN_BITS] == BASE_ADDR[17:BLOCK_ALIGN_BITS]);
	assign reg_idx = bus_req_i.addr[3:1];
	assign wr_any  = hit && bus_req_i.wr;
	assign rd_any  = hit && bus_req_i.rd;

	// Silo control terms.
	logic space, pop, fetch, silo_wr, pat_wr, scan_wr, scan_full, rx_int;
	msb_silo_word_t silo_wdata;
	assign space     = (count_q < (SILO_AW+1)'(SILO_DEPTH));
	assign pop       = rd_any && (reg_idx == REG_NEXT_RX) && head_valid_q;
	assign fetch     = !head_valid_q && !fetch_q && (mem_cnt_q != '0);
	// Pattern has priority over the scanner for the single write port.
	assign pat_wr    = maint_pend_q && space;
	assign scan_wr   = rx_char_available[scan_q] && space && !maint_pend_q;
	// Full silo keeps the character in its holding register.
	assign scan_full = rx_char_available[scan_q] && !space && !maint_pend_q;
	assign silo_wr   = pat_wr || scan_wr;
	assign silo_wdata = pat_wr ? msb_silo_word_t'(MAINT_PATTERN) :
		'{valid: 1'b1, overrun: rx_ovr[scan_q], frame_err: rx_ferr[scan_q],
		  par_err: rx_perr[scan_q], line: scan_q, data: rx_hold[scan_q]};
	// Alarm compare; needs a character at the output end.
	assign rx_int = ((count_q > {1'b0, alarm_q}) && head_valid_q) || ovf_q;

	// System control word fields owned by this block.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			line_sel_q <= '0;
			rx_ie_q    <= 1'b0;
			ovf_q      <= 1'b0;
		end else begin
			if (wr_any && reg_idx == REG_SYS_CTRL && bus_req_i.byte_en[0]) begin
				line_sel_q <= bus_req_i.wdata[SC_LINE_LSB +: LINE_W];
				rx_ie_q    <= bus_req_i.wdata[SC_RX_IE];
			end
			// Overflow set wins over a software clear.
			if (scan_full) begin
				ovf_q <= 1'b1;
			end else if (wr_any && reg_idx == REG_SYS_CTRL && bus_req_i.byte_en[1]
				&& !bus_req_i.wdata[SC_STORE_OVF]) begin
				ovf_q <= 1'b0;
			end
		end
	end

	// Silo status halves; each byte only moves with its own enable.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			alarm_q <= '0;
			maint_q <= 1'b0;
		end else if (wr_any && reg_idx == REG_SILO_STATUS) begin
			if (bus_req_i.byte_en[0]) begin
				alarm_q <= bus_req_i.wdata[SS_ALARM_LSB +: SILO_AW];
			end
			if (bus_req_i.byte_en[1]) begin
				maint_q <= bus_req_i.wdata[SS_MAINT];
			end
		end
	end

	// Maintenance edge detect; a held bit loads only once.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			maint_prev_q <= 1'b0;
			maint_pend_q <= 1'b0;
		end else begin
			maint_prev_q <= maint_q;
			if (maint_q && !maint_prev_q) begin
				maint_pend_q <= 1'b1;
			end else if (pat_wr) begin
				maint_pend_q <= 1'b0;
			end
		end
	end

	// Break bitmap, one bit per line, byte-wise writes.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			line_break_mask_q <= '0;
		end else if (wr_any && reg_idx == REG_BREAK) begin
			if (bus_req_i.byte_en[0]) begin
				line_break_mask_q[7:0] <= bus_req_i.wdata[7:0];
			end
			if (bus_req_i.byte_en[1]) begin
				line_break_mask_q[15:8] <= bus_req_i.wdata[15:8];
			end
		end
	end

	// Scanner visits every line in turn, one per clock.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			scan_q <= '0;
		end else begin
			scan_q <= scan_q + 1'b1;
		end
	end
	// One-hot take strobe to the scanned line.
	always_comb begin
		take_vec         = '0;
		take_vec[scan_q] = scan_wr;
	end

	// Silo pointers and the fill counter.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			wr_ptr_q  <= '0;
			rd_ptr_q  <= '0;
			mem_cnt_q <= '0;
			count_q   <= '0;
			fetch_q   <= 1'b0;
		end else begin
			wr_ptr_q  <= wr_ptr_q + SILO_AW'(silo_wr);
			rd_ptr_q  <= rd_ptr_q + SILO_AW'(fetch);
			mem_cnt_q <= mem_cnt_q + (SILO_AW+1)'(silo_wr) - (SILO_AW+1)'(fetch);
			// Up on load, down on read
			count_q   <= count_q + (SILO_AW+1)'(silo_wr) - (SILO_AW+1)'(pop);
			fetch_q   <= fetch;
		end
	end

	// Output stage of the silo; a read of the next-character word empties it.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			head_valid_q <= 1'b0;
			head_q       <= '0;
		end else if (fetch_q) begin
			head_valid_q <= 1'b1;
			head_q       <= mem_rdata;
		end else if (pop) begin
			head_valid_q <= 1'b0;
		end
	end

	// Silo storage.
	msb_silo_mem #(
		.WIDTH (16),
		.DEPTH (SILO_DEPTH),
		.AW    (SILO_AW)
	) u_mem (
		.clock_i   (clock_i),
		.wr_en_i   (silo_wr),
		.wr_addr_i (wr_ptr_q),
		.wr_data_i (silo_wdata),
		.rd_en_i   (fetch),
		.rd_addr_i (rd_ptr_q),
		.rd_data_o (mem_rdata)
	);

	// Register read-back; answer one cycle after the access.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			rdata_q <= WORD_RESET;
			ack_q   <= 1'b0;
		end else begin
			ack_q   <= hit && (bus_req_i.rd || bus_req_i.wr);
			rdata_q <= WORD_RESET;
			if (rd_any) begin
				unique case (reg_idx)
					REG_SYS_CTRL: begin
						rdata_q[SC_LINE_LSB +: LINE_W] <= line_sel_q;
						rdata_q[SC_RX_IE]              <= rx_ie_q;
						rdata_q[SC_RX_INT]             <= rx_int;
						rdata_q[SC_STORE_OVF]          <= ovf_q;
					end
					// An empty output end reads as all zero, valid bit clear.
					REG_NEXT_RX: begin
						rdata_q <= head_valid_q ? head_q : WORD_RESET;
					end
					REG_BREAK: begin
						rdata_q <= line_break_mask_q;
					end
					REG_SILO_STATUS: begin
						rdata_q[SS_ALARM_LSB +: SILO_AW] <= alarm_q;
						rdata_q[SS_XADDR_LSB +: 2]       <= tx_addr_hi_i[line_sel_q];
						rdata_q[SS_FILL_LSB +: SILO_AW]  <= count_q[SILO_AW-1:0];
						rdata_q[SS_MAINT]                <= maint_q;
					end
					// Line parameters, addresses, counts and active bits live elsewhere.
					default: begin
						rdata_q <= WORD_RESET;
					end
				endcase
			end
		end
	end

	// Interrupt request, registered.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= rx_int && rx_ie_q;
		end
	end

	assign bus_rdata_o = rdata_q;
	assign bus_ack_o   = ack_q;
	assign rx_irq_o    = irq_q;
	// Receiver vector is the lower one.
	assign rx_vector_o = RX_VECTOR;
	assign tx_vector_o = RX_VECTOR + 9'h004;

	// Per-line receiver and transmitter, ticks mark bit centres.
	for (genvar i = 0; i < LINES; i++) begin : g_line
		logic [3:0] rx_pos_q, tx_left_q;
		logic [7:0] rx_sh_q, tx_hold_q;
		logic       rx_busy_q, rx_par_q, tx_full_q, eoc_q, line_q, out_q;
		logic [10:0] tx_sh_q;
		logic       tx_start, rx_done;
		// A stop bit is due at one fixed position for each framing.
		assign rx_done  = rx_busy_q && rx_tick_i[i] &&
			(rx_pos_q == (parity_en_i[i] ? RX_STOP_PAR : RX_STOP_POS));
		// Move to shift register once it is empty.
		assign tx_start = tx_full_q && (tx_left_q == '0);

		always_ff @(posedge clock_i) begin
			if (!rst_n_i) begin
				rx_busy_q <= 1'b0;
				rx_pos_q  <= '0;
				rx_sh_q   <= '0;
				rx_par_q  <= 1'b0;
				rx_hold[i] <= '0;
				rx_char_available[i] <= 1'b0;
				rx_ovr[i]  <= 1'b0;
				rx_ferr[i] <= 1'b0;
				rx_perr[i] <= 1'b0;
			end else begin
				if (!rx_busy_q) begin
					rx_busy_q <= rx_tick_i[i] && !rx_serial_i[i];
					rx_pos_q  <= '0;
				end else if (rx_tick_i[i]) begin
					rx_pos_q <= rx_pos_q + 1'b1;
					// Data bits occupy every position before an unparitied stop bit.
					if (rx_pos_q < RX_STOP_POS) begin
						rx_sh_q <= {rx_serial_i[i], rx_sh_q[7:1]};
					end else if (!rx_done) begin
						rx_par_q <= rx_serial_i[i];
					end
					if (rx_done) begin
						rx_busy_q <= 1'b0;
					end
				end
				if (rx_done) begin
					rx_hold[i] <= rx_sh_q;
					rx_ferr[i] <= !rx_serial_i[i];
					rx_perr[i] <= parity_en_i[i] &&
						((^rx_sh_q ^ rx_par_q) != parity_odd_i[i]);
					rx_char_available[i] <= 1'b1;
				end else if (take_vec[i]) begin
					rx_char_available[i] <= 1'b0;
				end
				// A take in the same cycle wins over the overrun set and clears it.
				if (rx_done && rx_char_available[i] && !take_vec[i]) begin
					rx_ovr[i] <= 1'b1;
				end else if (take_vec[i]) begin
					rx_ovr[i] <= 1'b0;
				end
			end
		end

		always_ff @(posedge clock_i) begin
			if (!rst_n_i) begin
				tx_hold_q <= '0;
				tx_full_q <= 1'b0;
				tx_sh_q   <= '1;
				tx_left_q <= '0;
				eoc_q     <= 1'b0;
				line_q    <= 1'b1;
			end else begin
				if (tx_start) begin
					tx_full_q <= 1'b0;
					eoc_q     <= 1'b0;
					tx_sh_q   <= parity_en_i[i] ?
						{1'b1, ^tx_hold_q ^ parity_odd_i[i], tx_hold_q, 1'b0} :
						{2'b11, tx_hold_q, 1'b0};
					tx_left_q <= parity_en_i[i] ? FRAME_BITS_PAR : FRAME_BITS;
				end else if (tx_tick_i[i] && tx_left_q != '0) begin
					line_q    <= tx_sh_q[0];
					tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
					tx_left_q <= tx_left_q - 1'b1;
					eoc_q     <= (tx_left_q == 4'h1);
				end
				if (tx_load_i[i] && !tx_full_q) begin
					tx_hold_q <= tx_data_i[i];
					tx_full_q <= 1'b1;
				end
			end
		end

		// Break replaces every bit with space.
		always_ff @(posedge clock_i) begin
			if (!rst_n_i) begin
				out_q <= 1'b1;
			end else begin
				out_q <= line_q && !line_break_mask_q[i];
			end
		end

		assign tx_serial_o[i]        = out_q;
		assign tx_holding_empty_o[i] = !tx_full_q;
		assign tx_end_of_char_o[i]   = eoc_q;
	end

	// Checks kept beside the logic they guard.
	sequence s_maint_rise;
		maint_q && !maint_prev_q;
	endsequence
	sequence s_pattern_load;
		silo_wr && pat_wr;
	endsequence
	property p_break_space;
		@(posedge clock_i) disable iff (!rst_n_i)
		##1 ((tx_serial_o & $past(line_break_mask_q)) == '0);
	endproperty
	a_break_space: assert property (p_break_space) else $error("break line not at space");
	property p_pattern_once;
		@(posedge clock_i) disable iff (!rst_n_i)
		s_maint_rise ##1 (count_q < 7'h40) |-> s_pattern_load;
	endproperty
	a_pattern_once: assert property (p_pattern_once) else $error("pattern not loaded");
	property p_held_no_reload;
		@(posedge clock_i) disable iff (!rst_n_i)
		(maint_q && maint_prev_q && !maint_pend_q) |=> !pat_wr;
	endproperty
	a_held_no_reload: assert property (p_held_no_reload) else $error("held bit reloaded");
	property p_count_up;
		@(posedge clock_i) disable iff (!rst_n_i)
		(silo_wr && !pop) |=> (count_q == $past(count_q) + 7'h01);
	endproperty
	a_count_up: assert property (p_count_up) else $error("fill count did not rise");
	property p_count_cap;
		@(posedge clock_i) disable iff (!rst_n_i)
		count_q <= 7'h40;
	endproperty
	a_count_cap: assert property (p_count_cap) else $error("silo beyond 64 entries");
	property p_full_ovf;
		@(posedge clock_i) disable iff (!rst_n_i)
		scan_full |=> ovf_q && rx_char_available[$past(scan_q)];
	endproperty
	a_full_ovf: assert property (p_full_ovf) else $error("overflow not flagged");
	property p_irq_needs_head;
		@(posedge clock_i) disable iff (!rst_n_i)
		(!head_valid_q && !ovf_q) |=> !rx_irq_o;
	endproperty
	a_irq_needs_head: assert property (p_irq_needs_head) else $error("irq without char");
	property p_irq_alarm;
		@(posedge clock_i) disable iff (!rst_n_i)
		(rx_ie_q && head_valid_q && count_q > {1'b0, alarm_q}) |=> rx_irq_o;
	endproperty
	a_irq_alarm: assert property (p_irq_alarm) else $error("alarm irq missing");
	property p_low_byte_only;
		@(posedge clock_i) disable iff (!rst_n_i)
		(wr_any && reg_idx == REG_SILO_STATUS && !bus_req_i.byte_en[1]) |=> $stable(maint_q);
	endproperty
	a_low_byte_only: assert property (p_low_byte_only) else $error("upper half disturbed");
	property p_xaddr;
		@(posedge clock_i) disable iff (!rst_n_i)
		(rd_any && reg_idx == REG_SILO_STATUS) |=>
			rdata_q[SS_XADDR_LSB +: 2] == $past(tx_addr_hi_i[line_sel_q]);
	endproperty
	a_xaddr: assert property (p_xaddr) else $error("extended address wrong");

endmodule

// ### sim/msb_term_model.sv
`timescale 1ns/1ps
// Serial terminal on the far side of the receive lines; it also makes the bit-centre ticks.
module msb_term_model (
	input  wire logic        clock_i,
	output logic      [15:0] rx_serial_o,
	output logic      [15:0] rx_tick_o
);
	// Lines idle at mark, and no tick runs outside a frame.
	initial begin
		rx_serial_o = 16'hFFFF;
		rx_tick_o   = 16'h0000;
	end

	// Sends start, eight data bits LSB first and one stop bit, with a tick mid-bit.
	task automatic send(input int l, input logic [7:0] d);
		logic [9:0] fr;
		fr = {1'b1, d, 1'b0};
		for (int k = 0; k < 10; k++) begin
			rx_serial_o[l] <= fr[k];
			repeat (2) @(posedge clock_i);
			#1 rx_tick_o[l] <= 1'b1;
			@(posedge clock_i);
			#1 rx_tick_o[l] <= 1'b0;
		end
		// Back at mark so the next frame has a clean start edge.
		rx_serial_o[l] <= 1'b1;
		repeat (4) @(posedge clock_i);
		#1;
	endtask
endmodule

// ### sim/msb_silo_bench.sv
`timescale 1ns/1ps
// Compares a seen value with an expected one and counts the result.
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin fail_count++; \
	$display("ERROR %s expected %h seen %h", nm, ex, got); end end
module msb_silo_bench;
	import msb_pkg::*;
	logic                 clock_i;      // System clock.
	logic                 rst_n_i;      // Synchronous reset, active low.
	msb_bus_req_t         bus_req_i;    // Register access request.
	logic [15:0]          bus_rdata_o;  // Read data.
	logic                 bus_ack_o;    // Access acknowledge.
	logic [15:0]          rx_ser;       // Receive lines from the terminal.
	logic [15:0]          rx_tick;      // Receive bit ticks.
	logic [15:0]          tx_tick_i;    // Transmit bit ticks.
	logic [15:0]          tx_load_i;    // Transmit load strobes.
	logic [15:0][7:0]     tx_data_i;    // Transmit characters.
	logic [15:0][1:0]     tx_addr_hi_i; // Upper address bits per line.
	logic [15:0]          tx_serial_o;  // Transmit lines.
	logic [15:0]          tx_empty;     // Holding register empty flags.
	logic [15:0]          tx_eoc;       // End-of-character flags.
	logic                 rx_irq_o;     // Receiver interrupt request.
	logic [8:0]           rx_vector_o;  // Receiver vector.
	logic [8:0]           tx_vector_o;  // Transmitter vector.
	int                   fail_count;   // Mismatches seen.
	int                   checked;      // Comparisons made.
	int                   cyc;          // Cycles run, for the hang guard.

	msb_term_model msb_term_model_i (.clock_i(clock_i), .rx_serial_o(rx_ser), .rx_tick_o(rx_tick));

	msb_silo msb_silo_i (
		.clock_i(clock_i), .rst_n_i(rst_n_i), .bus_req_i(bus_req_i),
		.bus_rdata_o(bus_rdata_o), .bus_ack_o(bus_ack_o), .rx_serial_i(rx_ser),
		.rx_tick_i(rx_tick), .tx_tick_i(tx_tick_i), .parity_en_i(16'h0010),
		.parity_odd_i(16'hFFFF), .tx_load_i(tx_load_i), .tx_data_i(tx_data_i),
		.tx_addr_hi_i(tx_addr_hi_i), .tx_serial_o(tx_serial_o),
		.tx_holding_empty_o(tx_empty), .tx_end_of_char_o(tx_eoc), .rx_irq_o(rx_irq_o),
		.rx_vector_o(rx_vector_o), .tx_vector_o(tx_vector_o));

	// Free-running 200 MHz clock.
	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end

	// Hang guard: the tests need well under a tenth of this.
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 60000) begin
			fail_count++;
			print_verdict();
		end
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic print_verdict();
		$display("checked %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// One register access; off_b shifts the address out of the block when not zero.
	task automatic acc(input logic w, input logic [2:0] idx, input logic [1:0] be,
			input logic [15:0] wd, input logic ck, input logic [15:0] ex, input int off_b);
		bus_req_i <= '{1'b1, w, ~w, be, 18'h3_E010 + 18'(2 * idx) + 18'(off_b), wd};
		@(posedge clock_i);
		#1 bus_req_i <= '0;
		`CHK("ack", (off_b == 0), bus_ack_o)
		if (ck) `CHK("rdata", ex, bus_rdata_o)
		@(posedge clock_i);
		#1;
	endtask

	// Loads one character and follows it bit by bit on the line.
	task automatic tx_char(input int l, input logic [7:0] d, input logic brk);
		logic [10:0] fr;
		fr = {1'b1, ~(^d), d, 1'b0};
		tx_load_i[l] <= 1'b1;
		tx_data_i[l] <= d;
		@(posedge clock_i);
		#1 tx_load_i[l] <= 1'b0;
		repeat (2) @(posedge clock_i);
		#1 `CHK("tx empty", 1'b1, tx_empty[l])
		for (int k = 0; k < 12; k++) begin
			tx_tick_i[l] <= 1'b1;
			@(posedge clock_i);
			#1 tx_tick_i[l] <= 1'b0;
			repeat (2) @(posedge clock_i);
			#1;
			if (k < 11) `CHK("tx bit", (brk ? 1'b0 : fr[k]), tx_serial_o[l])
		end
		if (!brk) `CHK("eoc", 1'b1, tx_eoc[l])
	endtask

	initial begin
		fail_count = 0;
		checked = 0;
		cyc = 0;
		rst_n_i = 1'b0;
		bus_req_i = '0;
		tx_tick_i = '0;
		tx_load_i = '0;
		tx_data_i = '0;
		for (int i = 0; i < 16; i++) tx_addr_hi_i[i] = 2'(i);
		repeat (8) @(posedge clock_i);
		#1 rst_n_i = 1'b1;
		// Reset state, vectors and a miss just past the eight-word block.
		acc(0, REG_BREAK, 2'h3, 0, 1, 16'h0000, 0);
		acc(0, REG_SILO_STATUS, 2'h3, 0, 1, 16'h0000, 0);
		acc(0, REG_SYS_CTRL, 2'h3, 0, 1, 16'h0000, 16);
		`CHK("vec order", 1'b1, tx_vector_o > rx_vector_o)
		// Break forces space at once and swallows characters sent meanwhile.
		acc(1, REG_BREAK, 2'h3, 16'h0001, 0, 0, 0);
		`CHK("break", 1'b0, tx_serial_o[0])
		tx_char(0, 8'h00, 1);
		acc(1, REG_BREAK, 2'h3, 16'h0000, 0, 0, 0);
		`CHK("break off", 1'b1, tx_serial_o[0])
		tx_char(4, 8'hA5, 0);
		// Line 2 selected, receiver interrupt enabled, alarm level 1.
		acc(1, REG_SYS_CTRL, 2'h1, 16'h0042, 0, 0, 0);
		acc(1, REG_SILO_STATUS, 2'h1, 16'h0001, 0, 0, 0);
		acc(1, REG_SILO_STATUS, 2'h2, 16'h8000, 0, 0, 0);
		acc(1, REG_SILO_STATUS, 2'h2, 16'h8000, 0, 0, 0);
		acc(0, REG_SILO_STATUS, 2'h3, 0, 1, 16'h8181, 0);
		`CHK("irq low", 1'b0, rx_irq_o)
		acc(1, REG_SILO_STATUS, 2'h2, 16'h0000, 0, 0, 0);
		acc(1, REG_SILO_STATUS, 2'h2, 16'h8000, 0, 0, 0);
		repeat (3) @(posedge clock_i);
		#1 `CHK("irq high", 1'b1, rx_irq_o)
		acc(0, REG_NEXT_RX, 2'h3, 0, 1, MAINT_PATTERN, 0);
		repeat (3) @(posedge clock_i);
		#1;
		acc(0, REG_NEXT_RX, 2'h3, 0, 1, MAINT_PATTERN, 0);
		repeat (3) @(posedge clock_i);
		#1;
		acc(0, REG_NEXT_RX, 2'h3, 0, 1, 16'h0000, 0);
		acc(0, REG_SILO_STATUS, 2'h1, 0, 1, 16'h8081, 0);
		// A received character travels through the scanner into the silo.
		msb_term_model_i.send(3, 8'h5A);
		repeat (24) @(posedge clock_i);
		#1;
		acc(0, REG_NEXT_RX, 2'h3, 0, 1, 16'h835A, 0);
		// Fill to 64: the bit is still set, so clear it first to get a fresh rising edge.
		for (int i = 0; i < 64; i++) begin
			acc(1, REG_SILO_STATUS, 2'h2, 16'h0000, 0, 0, 0);
			acc(1, REG_SILO_STATUS, 2'h2, 16'h8000, 0, 0, 0);
		end
		// The last pattern lands two cycles after its write.
		repeat (2) @(posedge clock_i);
		#1;
		acc(0, REG_SILO_STATUS, 2'h3, 0, 1, 16'h8081, 0);
		// Overrun line 1 while the silo is full.
		msb_term_model_i.send(1, 8'h3C);
		msb_term_model_i.send(1, 8'h55);
		repeat (24) @(posedge clock_i);
		#1;
		acc(0, REG_SYS_CTRL, 2'h3, 0, 1, 16'h40C2, 0);
		for (int i = 0; i < 64; i++) begin
			repeat (3) @(posedge clock_i);
			#1;
			acc(0, REG_NEXT_RX, 2'h3, 0, 1, MAINT_PATTERN, 0);
		end
		repeat (24) @(posedge clock_i);
		#1;
		acc(0, REG_NEXT_RX, 2'h3, 0, 1, 16'hC155, 0);
		print_verdict();
	end
endmodule
